// >>> rtl/alr_consts.vh
// constants for the ambient light readout block
`ifndef ALR_CONSTS_VH
`define ALR_CONSTS_VH
`define ALR_DEV_ADDR 7'h13
`define ALR_REG_RESULT_HIGH 8'h85
`define ALR_REG_RESULT_LOW 8'h86
`define ALR_REG_CONFIG 8'h84
`define ALR_REG_AVG 8'h87
`define ALR_REG_STATUS 8'h80
`define ALR_CFG_CONT_BIT 7
`define ALR_CFG_START_BIT 0
`define ALR_CFG_RESET 8'h00
`define ALR_AVG_RESET 8'h01
`define ALR_AVG_MAX 8'h80
`define ALR_FRAME_NS 100000000
`define ALR_SINGLE_NS 300000
`define ALR_CLK_NS 25
`define ALR_FRAME_CYC (`ALR_FRAME_NS / `ALR_CLK_NS)
`define ALR_SINGLE_CYC ((`ALR_SINGLE_NS + `ALR_CLK_NS - 1) / `ALR_CLK_NS)
`endif

// >>> rtl/alr_conv_engine.v
// conversion timing and averaging engine for the ambient light measurement
`timescale 1ns/10ps
`include "alr_consts.vh"
module alr_conv_engine #(
  parameter [31:0] FRAME_CYC = `ALR_FRAME_CYC,
  parameter [31:0] SINGLE_CYC = `ALR_SINGLE_CYC
) (
  ref_clk,
  srst,
  clkEn,
  startReq,
  contMode,
  avgCount,
  sample,
  busy,
  resultValid,
  result
);
  input wire ref_clk;
  input wire srst;
  input wire clkEn;
  input wire startReq;
  input wire contMode;
  input wire [7:0] avgCount;
  input wire [15:0] sample;
  output reg busy;
  output reg resultValid;
  output reg [15:0] result;
  localparam ST_IDLE = 2'b00;
  localparam ST_MEAS = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [1:0] state_r;
  reg [31:0] frameCnt_r;
  reg [31:0] measCnt_r;
  reg [7:0] done_r;
  reg [7:0] target_r;
  reg [23:0] acc_r;
  reg contLatch_r;
  // average of acc over n samples, n in 1..128
  function [15:0] avgOf;
    input [23:0] acc;
    input [7:0] n;
    reg [23:0] quot;
    begin
      quot = acc;
      if (n != 8'h00) begin
        quot = acc / {16'h0000, n};
      end
      avgOf = quot[15:0];
    end
  endfunction
  always @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      frameCnt_r <= 32'h0;
      measCnt_r <= 32'h0;
      done_r <= 8'h00;
      target_r <= 8'h01;
      acc_r <= 24'h0;
      contLatch_r <= 1'b0;
      busy <= 1'b0;
      resultValid <= 1'b0;
      result <= 16'h0000;
    end else if (clkEn) begin
      resultValid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (startReq) begin
            state_r <= ST_MEAS;
            busy <= 1'b1;
            frameCnt_r <= 32'h0;
            measCnt_r <= 32'h0;
            done_r <= 8'h00;
            acc_r <= 24'h0;
            contLatch_r <= contMode;
            target_r <= (avgCount == 8'h00) ? 8'h01 :
              ((avgCount > `ALR_AVG_MAX) ? `ALR_AVG_MAX : avgCount);
          end
        end
        ST_MEAS: begin
          frameCnt_r <= frameCnt_r + 32'h1;
          if (measCnt_r == SINGLE_CYC - 32'h1) begin
            acc_r <= acc_r + {8'h00, sample};
            done_r <= done_r + 8'h01;
            measCnt_r <= 32'h0;
            if (done_r + 8'h01 == target_r) begin
              if (contLatch_r) begin
                // back to back samples, result as soon as last ends
                result <= avgOf(acc_r + {8'h00, sample}, target_r);
                resultValid <= 1'b1;
                state_r <= ST_IDLE;
                busy <= 1'b0;
              end else begin
                state_r <= ST_WAIT;
              end
            end
          end else begin
            measCnt_r <= measCnt_r + 32'h1;
          end
        end
        ST_WAIT: begin
          frameCnt_r <= frameCnt_r + 32'h1;
          // result released only at frame end
          if (frameCnt_r >= FRAME_CYC - 32'h1) begin
            result <= avgOf(acc_r, target_r);
            resultValid <= 1'b1;
            state_r <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> rtl/alr_pin_sync.v
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
module alr_pin_sync (
  ref_clk,
  srst,
  clkEn,
  pinIn,
  pinOut
);
  input wire ref_clk;
  input wire srst;
  input wire clkEn;
  input wire pinIn;
  output reg pinOut;
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge ref_clk) begin
    if (srst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      pinOut <= 1'b1;
    end else if (clkEn) begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        pinOut <= s3_r;
      end
    end
  end
endmodule

// >>> rtl/alr_top.v
// ambient light readout: i2c register slave with conversion engine
`timescale 1ns/10ps
`include "alr_consts.vh"
module alr_top #(
  parameter [31:0] FRAME_CYC = `ALR_FRAME_CYC
) (
  ref_clk,
  srst,
  clkEn,
  sclIn,
  sdaIn,
  sdaOut,
  sdaOe,
  lightSample,
  ledSinkEn,
  measBusy
);
  input wire ref_clk;
  input wire srst;
  input wire clkEn;
  input wire sclIn;
  input wire sdaIn;
  input wire [15:0] lightSample;
  output reg sdaOut;
  output reg sdaOe;
  output reg ledSinkEn;
  output reg measBusy;
  localparam BS_IDLE = 3'b000;
  localparam BS_ADDR = 3'b001;
  localparam BS_AACK = 3'b010;
  localparam BS_WRB = 3'b011;
  localparam BS_WACK = 3'b100;
  localparam BS_RDB = 3'b101;
  localparam BS_RACK = 3'b110;
  wire sclS;
  wire sdaS;
  wire engBusy;
  wire engValid;
  wire [15:0] engResult;
  reg sclD_r;
  reg sdaD_r;
  reg [2:0] bs_r;
  reg [3:0] bitCnt_r;
  reg [7:0] shift_r;
  reg [7:0] ptr_r;
  reg rw_r;
  reg firstByte_r;
  reg [7:0] cfg_r;
  reg [7:0] avg_r;
  reg [15:0] res_r;
  reg startPulse_r;
  reg [7:0] rdData;
  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  alr_pin_sync u_sync_scl (
    .ref_clk(ref_clk),
    .srst(srst),
    .clkEn(clkEn),
    .pinIn(sclIn),
    .pinOut(sclS)
  );
  alr_pin_sync u_sync_sda (
    .ref_clk(ref_clk),
    .srst(srst),
    .clkEn(clkEn),
    .pinIn(sdaIn),
    .pinOut(sdaS)
  );
  alr_conv_engine #(
    .FRAME_CYC(FRAME_CYC),
    .SINGLE_CYC(`ALR_SINGLE_CYC)
  ) u_engine (
    .ref_clk(ref_clk),
    .srst(srst),
    .clkEn(clkEn),
    .startReq(startPulse_r),
    .contMode(cfg_r[`ALR_CFG_CONT_BIT]),
    .avgCount(avg_r),
    .sample(lightSample),
    .busy(engBusy),
    .resultValid(engValid),
    .result(engResult)
  );
  assign sclRise = sclS & ~sclD_r;
  assign sclFall = ~sclS & sclD_r;
  assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
  assign stopCond = sclS & sclD_r & ~sdaD_r & sdaS;
  // read mux over the register map
  always @* begin
    case (ptr_r)
      `ALR_REG_STATUS: rdData = {7'h00, engBusy};
      `ALR_REG_CONFIG: rdData = cfg_r;
      `ALR_REG_RESULT_HIGH: rdData = res_r[15:8];
      `ALR_REG_RESULT_LOW: rdData = res_r[7:0];
      `ALR_REG_AVG: rdData = avg_r;
      default: rdData = 8'h00;
    endcase
  end
  always @(posedge ref_clk) begin
    if (srst) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
      bs_r <= BS_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      firstByte_r <= 1'b0;
      cfg_r <= `ALR_CFG_RESET;
      avg_r <= `ALR_AVG_RESET;
      res_r <= 16'h0000;
      startPulse_r <= 1'b0;
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
      ledSinkEn <= 1'b0;
      measBusy <= 1'b0;
    end else if (clkEn) begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
      startPulse_r <= 1'b0;
      measBusy <= engBusy;
      ledSinkEn <= 1'b0;
      if (engValid) begin
        res_r <= engResult;
      end
      // a start request stays set until the engine picks it up
      if (cfg_r[`ALR_CFG_START_BIT] && !engBusy && !startPulse_r) begin
        startPulse_r <= 1'b1;
        cfg_r[`ALR_CFG_START_BIT] <= 1'b0;
      end
      if (stopCond) begin
        bs_r <= BS_IDLE;
        sdaOe <= 1'b0;
      end else if (startCond) begin
        bs_r <= BS_ADDR;
        bitCnt_r <= 4'h0;
        sdaOe <= 1'b0;
      end else begin
        case (bs_r)
          BS_IDLE: begin
            sdaOe <= 1'b0;
          end
          BS_ADDR: begin
            if (sclRise) begin
              shift_r <= {shift_r[6:0], sdaS};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              if (shift_r[7:1] == `ALR_DEV_ADDR) begin
                rw_r <= shift_r[0];
                sdaOut <= 1'b0;
                sdaOe <= 1'b1;
                bs_r <= BS_AACK;
                firstByte_r <= 1'b1;
              end else begin
                bs_r <= BS_IDLE;
              end
            end
          end
          BS_AACK: begin
            if (sclFall) begin
              bitCnt_r <= 4'h0;
              if (rw_r) begin
                // open drain: only a zero bit pulls the line
                sdaOut <= 1'b0;
                shift_r <= rdData;
                sdaOe <= ~rdData[7];
                bs_r <= BS_RDB;
              end else begin
                sdaOe <= 1'b0;
                bs_r <= BS_WRB;
              end
            end
          end
          BS_WRB: begin
            if (sclRise) begin
              shift_r <= {shift_r[6:0], sdaS};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              if (firstByte_r) begin
                ptr_r <= shift_r;
                firstByte_r <= 1'b0;
              end else begin
                if (ptr_r == `ALR_REG_CONFIG) begin
                  cfg_r <= shift_r;
                end else if (ptr_r == `ALR_REG_AVG) begin
                  avg_r <= shift_r;
                end
                ptr_r <= ptr_r + 8'h01;
              end
              sdaOut <= 1'b0;
              sdaOe <= 1'b1;
              bs_r <= BS_WACK;
            end
          end
          BS_WACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              bitCnt_r <= 4'h0;
              bs_r <= BS_WRB;
            end
          end
          BS_RDB: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h7) begin
                sdaOe <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
                bs_r <= BS_RACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sdaOut <= 1'b0;
                sdaOe <= ~shift_r[6];
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          BS_RACK: begin
            if (sclRise) begin
              rw_r <= ~sdaS;
            end else if (sclFall) begin
              bitCnt_r <= 4'h0;
              if (rw_r) begin
                sdaOut <= 1'b0;
                shift_r <= rdData;
                sdaOe <= ~rdData[7];
                bs_r <= BS_RDB;
              end else begin
                bs_r <= BS_IDLE;
              end
            end
          end
          default: begin
            bs_r <= BS_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// >>> verification/alr_host.sv
// i2c host model for the ambient light readout
`timescale 1ns/10ps
module alr_host (
  input wire ref_clk,
  input wire sdaWire,
  output reg sclOut,
  output reg sdaDrv
);
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end
  task hold;
    begin
      repeat (8) @(posedge ref_clk);
      #1;
    end
  endtask
  // start or repeated start, pointer kept either way
  task start;
    begin
      sdaDrv = 1'b1;
      hold;
      sclOut = 1'b1;
      hold;
      sdaDrv = 1'b0;
      hold;
      sclOut = 1'b0;
      hold;
    end
  endtask
  task stop;
    begin
      sdaDrv = 1'b0;
      hold;
      sclOut = 1'b1;
      hold;
      sdaDrv = 1'b1;
      hold;
    end
  endtask
  // eight data bits then the acknowledge bit, msb first
  task byteIo(input [8:0] d, output [8:0] q);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        sdaDrv = d[i];
        hold;
        sclOut = 1'b1;
        hold;
        q[i] = sdaWire;
        sclOut = 1'b0;
      end
    end
  endtask
endmodule

// >>> verification/alr_monitor.sv
// port checker for the ambient light readout
`timescale 1ns/10ps
module alr_monitor #(
  parameter [31:0] FRAME_CYC = 32'd4000000
) (
  input wire ref_clk,
  input wire srst,
  input wire clkEn,
  input wire sclIn,
  input wire sdaIn,
  input wire [15:0] lightSample,
  input wire sdaOut,
  input wire sdaOe,
  input wire ledSinkEn,
  input wire measBusy
);
  reg [31:0] busyLen_r;
  reg [9:0] sinceOe_r;
  always @(posedge ref_clk) begin
    if (srst) begin
      busyLen_r <= 32'h0;
      sinceOe_r <= 10'h3FF;
    end else begin
      busyLen_r <= measBusy ? busyLen_r + 32'h1 : 32'h0;
      sinceOe_r <= sdaOe ? 10'h0 : sinceOe_r + {9'h0, sinceOe_r != 10'h3FF};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  led_off_a: assert property (!ledSinkEn)
    else $error("led sink enabled");
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> !sdaOe && !measBusy)
    else $error("outputs active after reset");
  drive_low_a: assert property (sdaOe |-> !sdaOut)
    else $error("sda driven high");
  oe_rise_a: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("sda taken while scl high");
  oe_fall_a: assert property ($fell(sdaOe) |-> !sclIn)
    else $error("sda released while scl high");
  busy_max_a: assert property (busyLen_r <= FRAME_CYC + 32'd4)
    else $error("measurement longer than frame");
  busy_min_a: assert property ($fell(measBusy) |-> busyLen_r >= 32'd11996)
    else $error("measurement shorter than one sample");
  busy_cause_a: assert property ($rose(measBusy) |-> sinceOe_r < 10'd400)
    else $error("measurement without bus request");
endmodule
bind alr_top alr_monitor #(.FRAME_CYC(FRAME_CYC)) mon (.ref_clk(ref_clk), .srst(srst),
  .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn), .lightSample(lightSample), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .ledSinkEn(ledSinkEn), .measBusy(measBusy));

// >>> verification/ambient_light_readout_tb.sv
// self-checking bench for the ambient light readout
`timescale 1ns/10ps
`define CHK(a, e) begin nChecks = nChecks + 1; if ((a) !== (e)) begin \
  errors = errors + 1; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module ambient_light_readout_tb;
  localparam [31:0] FRAME = 32'd30000;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg [15:0] lightSample = 16'h0000;
  wire sclOut;
  wire sdaDrv;
  wire sdaOut;
  wire sdaOe;
  wire ledSinkEn;
  wire measBusy;
  wire sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  integer errors = 0;
  integer nChecks = 0;
  reg [31:0] runLen = 32'h0;
  reg [31:0] doneLen = 32'h0;
  reg [7:0] rd [0:2];
  reg [8:0] q;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (measBusy === 1'b1) runLen <= runLen + 32'h1;
    else if (runLen != 32'h0) begin
      doneLen <= runLen;
      runLen <= 32'h0;
    end
  end
  alr_top #(.FRAME_CYC(FRAME)) dut (.ref_clk(ref_clk), .srst(srst), .clkEn(1'b1),
    .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .lightSample(lightSample), .ledSinkEn(ledSinkEn), .measBusy(measBusy));
  alr_host host (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(sclOut), .sdaDrv(sdaDrv));
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task regWrite(input [7:0] ptr, input [7:0] val);
    begin
      host.start;
      host.byteIo({8'h26, 1'b1}, q);
      `CHK(q[0], 1'b0)
      host.byteIo({ptr, 1'b1}, q);
      host.byteIo({val, 1'b1}, q);
      host.stop;
    end
  endtask
  task readRegs(input [7:0] ptr, input rs, input integer n);
    integer i;
    begin
      host.start;
      host.byteIo({8'h26, 1'b1}, q);
      host.byteIo({ptr, 1'b1}, q);
      if (!rs) host.stop;
      host.start;
      host.byteIo({8'h27, 1'b1}, q);
      `CHK(q[0], 1'b0)
      for (i = 0; i < n; i = i + 1) begin
        host.byteIo({8'hFF, i == n - 1}, q);
        rd[i] = q[8:1];
      end
      host.stop;
    end
  endtask
  task waitDone(input [31:0] expLen);
    integer n;
    begin
      n = 0;
      while (doneLen == 32'h0 && n < 40000) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (n >= 40000) begin
        errors = errors + 1;
        stop_test;
      end
      `CHK(doneLen + 32'd4 >= expLen && doneLen <= expLen + 32'd4, 1'b1)
    end
  endtask
  task t_idle;
    begin
      `CHK({measBusy, sdaOe, ledSinkEn}, 3'h0)
      host.start;
      host.byteIo({8'h28, 1'b1}, q);
      `CHK(q[0], 1'b1)
      host.stop;
      readRegs(8'h85, 1'b0, 2);
      `CHK({rd[0], rd[1]}, 16'h0000)
      $display("test done: idle");
    end
  endtask
  task t_standard;
    begin
      lightSample = 16'h1234;
      regWrite(8'h87, 8'h02);
      doneLen = 32'h0;
      regWrite(8'h84, 8'h01);
      waitDone(FRAME);
      readRegs(8'h85, 1'b0, 2);
      `CHK(rd[0], 8'h12)
      `CHK(rd[1], 8'h34)
      $display("test done: standard");
    end
  endtask
  task t_continuous;
    begin
      lightSample = 16'h1000;
      doneLen = 32'h0;
      regWrite(8'h84, 8'h81);
      repeat (18000) @(posedge ref_clk);
      #1 lightSample = 16'h2003;
      waitDone(32'd24000);
      readRegs(8'h85, 1'b1, 3);
      `CHK({rd[0], rd[1]}, 16'h1801)
      `CHK(rd[2], 8'h02)
      $display("test done: continuous");
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    t_idle;
    t_standard;
    t_continuous;
    stop_test;
  end
endmodule
